// >>> cos_regs.svh
// Register offsets, field positions and reset values of the contact output selector.
`ifndef COS_REGS_SVH
`define COS_REGS_SVH

`define COS_ADDR_W        8
`define COS_DATA_W        32
`define COS_NUM_OUT       3
`define COS_NUM_ALARM     36

`define COS_CFG_BASE      8'h00
`define COS_ALM_BASE      8'h0C
`define COS_STAT_ADDR     8'h18
`define COS_OUT_STRIDE    8'h04

`define COS_SRC_LSB       0
`define COS_SRC_MSB       3
`define COS_POL_BIT       4
`define COS_ALM_LSB       0
`define COS_ALM_MSB       5

`define COS_ALM_MIN       6'h01
`define COS_ALM_MAX       6'h24
`define COS_ALM_RST       6'h01

`define COS_SRC_RST0      4'h1
`define COS_SRC_RST1      4'h2
`define COS_SRC_RST2      4'h6
`define COS_POL_RST0      1'b0
`define COS_POL_RST1      1'b0
`define COS_POL_RST2      1'b1

`define COS_STAT_OUT_LSB  0
`define COS_STAT_SRC_LSB  8

`endif

// >>> cos_pkg.sv
// Types shared by the contact output selector.
`default_nettype none
package cos_pkg;

	typedef enum logic [3:0] {
		COS_SRC_NONE        = 4'h0,
		COS_SRC_RUNNING     = 4'h1,
		COS_SRC_REMOTE      = 4'h2,
		COS_SRC_READY       = 4'h3,
		stop_alarm_source   = 4'h4,
		COS_SRC_CONT_ALARM  = 4'h5,
		COS_SRC_ANY_ALARM   = 4'h6,
		COS_SRC_SEL_ALARM   = 4'h7,
		COS_SRC_RUN_TIMER   = 4'h8,
		stop_timer_armed_source = 4'h9,
		COS_SRC_PWR_RECOVER = 4'hA,
		COS_SRC_ANTIFREEZE  = 4'hB,
		input_one_passthrough = 4'hC,
		COS_SRC_INPUT_TWO   = 4'hD,
		COS_SRC_FILLING     = 4'hE
	} cos_src_e;

	typedef struct packed {
		logic running;
		logic remote;
		logic ready;
		logic run_timer_armed;
		logic stop_timer_armed;
		logic pwr_recover_en;
		logic antifreeze_en;
		logic contact_in1;
		logic contact_in2;
		logic filling;
	} cos_status_s;

	typedef struct packed {
		logic     normally_closed;
		cos_src_e src;
	} cos_cfg_s;

endpackage
`default_nettype wire

// >>> cos_top.sv
// Contact output selector: routes status sources onto three relay contacts.
`timescale 1ns/1ps
`include "cos_regs.svh"
`default_nettype none

// Register map; every word sits on a four-byte step.
//   0x00  Contact 1 settings: bits 3:0 source code, bit 4 closed type.
//   0x04  Contact 2 settings, laid out as for contact 1.
//   0x08  Contact 3 settings, laid out as for contact 1.
//   0x0C  Contact 1 alarm number in bits 5:0, from 1 to 36.
//   0x10  Contact 2 alarm number, laid out as for contact 1.
//   0x14  Contact 3 alarm number, laid out as for contact 1.
//   0x18  Read-only status: bits 2:0 contacts, bits 10:8 raw sources.
// Other addresses ignore writes and read back as zero.
//
// Source codes, shared by all three contacts:
//   0x0  No source; the contact stays open in either type.
//   0x1  Unit operating.
//   0x2  Remote control in force.
//   0x3  Temperature ready.
//   0x4  An alarm of the stopping class is present.
//   0x5  An alarm of the continuing class is present.
//   0x6  Any alarm is present.
//   0x7  The alarm whose number is stored for this contact.
//   0x8  Run timer armed.
//   0x9  Stop timer armed.
//   0xA  Power-failure recovery enabled.
//   0xB  Anti-freezing protection enabled.
//   0xC  Contact input 1 passed through.
//   0xD  Contact input 2 passed through.
//   0xE  Automatic fluid filling running.
//   0xF  Refused; a write carrying it keeps the old source.
//
// Reset values: contact 1 follows the run state, open type; contact 2
// follows remote control, open type; contact 3 follows any alarm,
// closed type, so it closes from the first edge after reset when no
// alarm is present. Every alarm number starts at 1.
//
// A write lands at its strobe edge and reaches the pin one edge later.
// Read data stand only in the cycle after the strobe and are zero
// otherwise, so several readers can share an OR-combined bus.
// The contacts are registered so the relay drivers never see the
// glitches of the source multiplexer.
//
// An alarm number is kept while its contact follows another source,
// so returning to the selected-alarm source restores the last choice.
// The trade-off is that software cannot check the hidden number
// before it switches the source back.
//
// Bit k of the alarm inputs stands for alarm number k+1; the class
// input is 1 for an alarm that stops the unit and 0 for one that
// lets it continue. The class bit is ignored while its alarm is absent.
//
// The status word shows the raw source levels before the polarity
// is applied, so software can tell a closed-type contact at rest
// from one whose source has dropped.

module cos_top #(
	parameter int NUM_ALARM = `COS_NUM_ALARM
) (
	input  wire logic                        core_clk,
	input  wire logic                        resetn,
	// Register port.
	input  wire logic [`COS_ADDR_W-1:0]      reg_addr,
	input  wire logic [`COS_DATA_W-1:0]      reg_wdata,
	input  wire logic                        reg_wr,
	input  wire logic                        reg_rd,
	output logic      [`COS_DATA_W-1:0]      reg_rdata,
	// Status levels, alarms and relay contacts.
	input  wire cos_pkg::cos_status_s        status_in,
	input  wire logic [NUM_ALARM-1:0]        alarm_active,
	input  wire logic [NUM_ALARM-1:0]        alarm_stop_class,
	output logic      [`COS_NUM_OUT-1:0]     contact_out
);

	// Reset choices per contact, indexed by contact number minus one.
	// Contact 3 alone starts with the closed type.
	localparam logic [3:0] SRC_RST [`COS_NUM_OUT] = '{
		`COS_SRC_RST0, `COS_SRC_RST1, `COS_SRC_RST2
	};
	localparam logic POL_RST [`COS_NUM_OUT] = '{
		`COS_POL_RST0, `COS_POL_RST1, `COS_POL_RST2
	};

	logic [`COS_DATA_W-1:0]        cfg_word_q [`COS_NUM_OUT];
	logic [`COS_DATA_W-1:0]        alm_word_q [`COS_NUM_OUT];
	logic [`COS_NUM_OUT-1:0]       cfg_sel_w;
	logic [`COS_NUM_OUT-1:0]       alm_sel_w;
	logic [NUM_ALARM-1:0]          stop_hit_w;
	logic [NUM_ALARM-1:0]          cont_hit_w;
	logic [`COS_NUM_OUT-1:0]       level_w;
	logic [`COS_NUM_OUT-1:0]       src_w;
	logic                          stop_alarm_w;
	logic                          cont_alarm_w;
	logic                          any_alarm_w;
	logic [`COS_DATA_W-1:0]        rdata_nxt;
	logic [`COS_DATA_W-1:0]        reg_rdata_r;
	logic [`COS_NUM_OUT-1:0]       contact_r;

	// Alarm class summaries shared by every output. An alarm counts
	// only while it is present; its class bit alone does nothing.
	genvar ai;
	generate
		for (ai = 0; ai < NUM_ALARM; ai++) begin : g_alarm
			// Each present alarm falls into exactly one class.
			assign stop_hit_w[ai] = alarm_active[ai] & alarm_stop_class[ai];
			assign cont_hit_w[ai] = alarm_active[ai] & ~alarm_stop_class[ai];
		end
	endgenerate
	assign stop_alarm_w = |stop_hit_w;
	assign cont_alarm_w = |cont_hit_w;
	assign any_alarm_w  = |alarm_active;

	// One slice per contact; the slices share the bus, the status inputs and the alarm summaries.
	genvar gi;
	generate
		for (gi = 0; gi < `COS_NUM_OUT; gi++) begin : g_out
			localparam logic [`COS_ADDR_W-1:0] CFG_ADDR =
				`COS_ADDR_W'(`COS_CFG_BASE + gi * `COS_OUT_STRIDE);
			localparam logic [`COS_ADDR_W-1:0] ALM_ADDR =
				`COS_ADDR_W'(`COS_ALM_BASE + gi * `COS_OUT_STRIDE);

			cos_pkg::cos_cfg_s     cfg_r;
			logic [`COS_ALM_MSB:0] alm_r;
			logic [`COS_ALM_MSB:0] alm_wr;
			logic                  sel_alarm_w;
			logic                  src_level;
			logic                  level_bit;
			logic                  cfg_hit_w;
			logic                  alm_hit_w;
			logic                  src_ok_w;
			logic                  alm_ok_w;
			logic [`COS_DATA_W-1:0] cfg_word;
			logic [`COS_DATA_W-1:0] alm_word;

			assign alm_wr = reg_wdata[`COS_ALM_MSB:`COS_ALM_LSB];
			assign sel_alarm_w =
				(cfg_r.src == cos_pkg::COS_SRC_SEL_ALARM);

			// Write decode for the two words of this contact.
			assign cfg_hit_w = reg_wr && (reg_addr == CFG_ADDR);
			assign alm_hit_w = reg_wr && (reg_addr == ALM_ADDR);

			// Code 0xF names no source, so such a write keeps the old
			// source; the polarity bit of the same word still lands.
			assign src_ok_w = (reg_wdata[`COS_SRC_MSB:`COS_SRC_LSB] <=
			                   cos_pkg::COS_SRC_FILLING);

			// Numbers outside the alarm range are dropped, not clamped,
			// so a mistyped value never points at a neighbouring alarm.
			// The number is writable only while this contact follows
			// the selected alarm.
			assign alm_ok_w = sel_alarm_w &&
				alm_wr >= `COS_ALM_MIN &&
				alm_wr <= `COS_ALM_MAX;

			// Unknown source codes are refused so the selector never
			// holds a value that no table entry describes.
			always_ff @(posedge core_clk or negedge resetn) begin
				if (!resetn) begin
					cfg_r.src <= cos_pkg::cos_src_e'(SRC_RST[gi]);
					cfg_r.normally_closed <= POL_RST[gi];
				end else if (cfg_hit_w) begin
					cfg_r.normally_closed <= reg_wdata[`COS_POL_BIT];
					if (src_ok_w) begin
						cfg_r.src <= cos_pkg::cos_src_e'(
							reg_wdata[`COS_SRC_MSB:`COS_SRC_LSB]);
					end
				end
			end

			// The alarm number keeps its value while hidden, so switching
			// back to the selected-alarm source restores the last choice.
			always_ff @(posedge core_clk or negedge resetn) begin
				if (!resetn) begin
					alm_r <= `COS_ALM_RST;
				end else if (alm_hit_w && alm_ok_w) begin
					alm_r <= alm_wr;
				end
			end

			always_comb begin
				case (cfg_r.src)
					cos_pkg::COS_SRC_NONE: begin
						src_level = 1'b0;
					end
					cos_pkg::COS_SRC_RUNNING: begin
						src_level = status_in.running;
					end
					cos_pkg::COS_SRC_REMOTE: begin
						src_level = status_in.remote;
					end
					cos_pkg::COS_SRC_READY: begin
						src_level = status_in.ready;
					end
					cos_pkg::stop_alarm_source: begin
						src_level = stop_alarm_w;
					end
					cos_pkg::COS_SRC_CONT_ALARM: begin
						src_level = cont_alarm_w;
					end
					cos_pkg::COS_SRC_ANY_ALARM: begin
						src_level = any_alarm_w;
					end
					// The stored number is never below 1, so the
					// index stays inside the alarm vector.
					cos_pkg::COS_SRC_SEL_ALARM: begin
						src_level = alarm_active[alm_r - 6'h01];
					end
					cos_pkg::COS_SRC_RUN_TIMER: begin
						src_level = status_in.run_timer_armed;
					end
					cos_pkg::stop_timer_armed_source: begin
						src_level = status_in.stop_timer_armed;
					end
					cos_pkg::COS_SRC_PWR_RECOVER: begin
						src_level = status_in.pwr_recover_en;
					end
					cos_pkg::COS_SRC_ANTIFREEZE: begin
						src_level = status_in.antifreeze_en;
					end
					cos_pkg::input_one_passthrough: begin
						src_level = status_in.contact_in1;
					end
					cos_pkg::COS_SRC_INPUT_TWO: begin
						src_level = status_in.contact_in2;
					end
					cos_pkg::COS_SRC_FILLING: begin
						src_level = status_in.filling;
					end
					default: begin
						src_level = 1'b0;
					end
				endcase
			end

			// With no source the contact stays inactive in either
			// polarity, so an unused relay never closes on its own.
			// The closed type is applied after the multiplexer, so every
			// source shares the same path to the pin.
			always_comb begin
				if (cfg_r.src == cos_pkg::COS_SRC_NONE) begin
					level_bit = 1'b0;
				end else if (cfg_r.normally_closed) begin
					level_bit = ~src_level;
				end else begin
					level_bit = src_level;
				end
			end
			assign level_w[gi] = level_bit;
			assign src_w[gi] = src_level;

			// Read words of this contact. The alarm word reads as zero
			// while the number is hidden behind another source.
			always_comb begin
				cfg_word = '0;
				cfg_word[`COS_SRC_MSB:`COS_SRC_LSB] = cfg_r.src;
				cfg_word[`COS_POL_BIT] = cfg_r.normally_closed;
			end

			always_comb begin
				alm_word = '0;
				if (sel_alarm_w) begin
					alm_word[`COS_ALM_MSB:`COS_ALM_LSB] = alm_r;
				end
			end

			assign cfg_word_q[gi] = cfg_word;
			assign alm_word_q[gi] = alm_word;
			assign cfg_sel_w[gi]  = (reg_addr == CFG_ADDR);
			assign alm_sel_w[gi]  = (reg_addr == ALM_ADDR);
		end
	endgenerate

	// One register for all three contacts keeps their edges aligned,
	// so equipment that reads them together never sees a mixed state.
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			contact_r <= '0;
		end else begin
			contact_r <= level_w;
		end
	end

	// Read decode. Only one address can match, so the order of the
	// chain decides nothing; an unmatched address leaves zero.
	always_comb begin
		rdata_nxt = '0;
		if (reg_addr == `COS_STAT_ADDR) begin
			rdata_nxt[`COS_STAT_OUT_LSB +: `COS_NUM_OUT] = contact_r;
			rdata_nxt[`COS_STAT_SRC_LSB +: `COS_NUM_OUT] = src_w;
		end else begin
			for (int i = 0; i < `COS_NUM_OUT; i++) begin
				if (cfg_sel_w[i]) begin
					rdata_nxt = cfg_word_q[i];
				end else if (alm_sel_w[i]) begin
					rdata_nxt = alm_word_q[i];
				end
			end
		end
	end

	// Read data stand only in the cycle after the strobe. Clearing
	// them afterwards lets a checker see stray data at once.
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			reg_rdata_r <= '0;
		end else if (reg_rd) begin
			reg_rdata_r <= rdata_nxt;
		end else begin
			reg_rdata_r <= '0;
		end
	end

	assign reg_rdata   = reg_rdata_r;
	assign contact_out = contact_r;

endmodule // cos_top

`default_nettype wire

// >>> cos_top_asserts.sv
// Port checker for the contact output selector.
`timescale 1ns/1ps
`include "cos_regs.svh"
`default_nettype none
module cos_top_chk #(
	parameter int NUM_ALARM = `COS_NUM_ALARM
) (
	input wire logic                    core_clk,
	input wire logic                    resetn,
	input wire logic [`COS_ADDR_W-1:0]  reg_addr,
	input wire logic [`COS_DATA_W-1:0]  reg_wdata,
	input wire logic                    reg_wr,
	input wire logic                    reg_rd,
	input wire logic [`COS_DATA_W-1:0]  reg_rdata,
	input wire cos_pkg::cos_status_s    status_in,
	input wire logic [NUM_ALARM-1:0]    alarm_active,
	input wire logic [NUM_ALARM-1:0]    alarm_stop_class,
	input wire logic [`COS_NUM_OUT-1:0] contact_out
);
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!resetn);
	property p_rd_idle;
		!$past(reg_rd) |-> reg_rdata == 32'h0;
	endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("stray data");
	property p_unmap;
		reg_rd && reg_addr > 8'h18 |=> reg_rdata == 32'h0;
	endproperty
	a_unmap: assert property (p_unmap) else $error("unmapped data");
	property p_alm;
		reg_rd && reg_addr inside {8'h0C, 8'h10, 8'h14} |=> reg_rdata <= 32'h24;
	endproperty
	a_alm: assert property (p_alm) else $error("alarm out of range");
	property p_cfg;
		reg_rd && reg_addr inside {8'h00, 8'h04, 8'h08}
			|=> reg_rdata[31:5] == 27'h0 && reg_rdata[3:0] != 4'hF;
	endproperty
	a_cfg: assert property (p_cfg) else $error("bad setting");
	property p_stat;
		reg_rd && reg_addr == 8'h18
			|=> reg_rdata[31:11] == 21'h0 && reg_rdata[7:3] == 5'h0;
	endproperty
	a_stat: assert property (p_stat) else $error("bad status");
	property p_hold;
		$past(resetn) && !$past(reg_wr) && $stable(status_in)
			&& $stable(alarm_active) && $stable(alarm_stop_class)
			|=> $stable(contact_out);
	endproperty
	a_hold: assert property (p_hold) else $error("contact moved");
	property p_off1;
		reg_wr && reg_addr == 8'h00 && reg_wdata[3:0] == 4'h0 ##1 !reg_wr
			|=> !contact_out[0];
	endproperty
	a_off1: assert property (p_off1) else $error("contact 1 on");
	property p_off3;
		reg_wr && reg_addr == 8'h08 && reg_wdata[3:0] == 4'h0 ##1 !reg_wr
			|=> !contact_out[2];
	endproperty
	a_off3: assert property (p_off3) else $error("contact 3 on");
	c_wr: cover property (reg_wr);
	c_rd: cover property (reg_rd ##1 reg_rdata != 32'h0);
	c_on: cover property ($rose(contact_out[0]));
endmodule // cos_top_chk
bind cos_top cos_top_chk #(.NUM_ALARM(NUM_ALARM)) cos_top_chk_i (
	.core_clk(core_clk), .resetn(resetn), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata), .status_in(status_in),
	.alarm_active(alarm_active), .alarm_stop_class(alarm_stop_class),
	.contact_out(contact_out));
`default_nettype wire

// >>> cos_equip.sv
// Customer equipment model that reads the relay contacts.
`timescale 1ns/1ps
`default_nettype none
module cos_equip (
	input  wire logic       core_clk,
	input  wire logic       resetn,
	input  wire logic [2:0] contact_in,
	output logic      [2:0] seen
);
	// The equipment only listens, so it latches the contacts every cycle.
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn)
			seen <= 3'h0;
		else
			seen <= contact_in;
	end
endmodule // cos_equip
`default_nettype wire

// >>> test_cos_top.sv
// Self-checking bench for the contact output selector.
`timescale 1ns/1ps
`default_nettype none
module test_cos_top;
	logic                 core_clk = 1'b0;
	logic                 resetn = 1'b0;
	logic [7:0]           reg_addr = 8'h00;
	logic [31:0]          reg_wdata = 32'h0;
	logic                 reg_wr = 1'b0;
	logic                 reg_rd = 1'b0;
	logic [31:0]          reg_rdata;
	cos_pkg::cos_status_s status_in = '0;
	logic [35:0]          alarm_active = 36'h0;
	logic [35:0]          alarm_stop_class = 36'h0;
	logic [2:0]           contact_out;
	logic [2:0]           seen;
	logic [3:0]           codes [10] = '{4'h1, 4'h2, 4'h3, 4'h8, 4'h9,
		4'hA, 4'hB, 4'hC, 4'hD, 4'hE};
	int                   err_count = 0;
	int                   cmp_count = 0;
	always #5 core_clk = ~core_clk;
	cos_top cos_top_i (.core_clk(core_clk), .resetn(resetn),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .status_in(status_in),
		.alarm_active(alarm_active), .alarm_stop_class(alarm_stop_class),
		.contact_out(contact_out));
	cos_equip cos_equip_i (.core_clk(core_clk), .resetn(resetn),
		.contact_in(contact_out), .seen(seen));
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1;
		cmp_count++;
		if (reg_rdata !== e)
			$display("Error %0t read %h got %h", $time, a, reg_rdata);
		if (reg_rdata !== e)
			err_count++;
	endtask
	task automatic chk(input logic [2:0] e);
		repeat (3) @(posedge core_clk);
		#1;
		cmp_count++;
		if (seen !== e)
			$display("Error %0t contacts %b want %b", $time, seen, e);
		if (seen !== e)
			err_count++;
	endtask
	task automatic drv(input logic [9:0] s, input logic [35:0] a, c);
		@(posedge core_clk);
		status_in <= cos_pkg::cos_status_s'(s);
		alarm_active <= a;
		alarm_stop_class <= c;
	endtask
	task automatic results;
		$display("compares %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	initial begin
		repeat (20) @(posedge core_clk);
		resetn <= 1'b1;
		rd(8'h00, 32'h01);
		rd(8'h04, 32'h02);
		rd(8'h08, 32'h16);
		rd(8'h0C, 32'h0);
		chk(3'b100);
		rd(8'h18, 32'h04);
		$display("defaults test done");
		wr(8'h04, 32'h0);
		for (int i = 0; i < 10; i++) begin
			wr(8'h00, {28'h0, codes[i]});
			drv(10'h000, 36'h0, 36'h0);
			chk(3'b100);
			drv(10'h200 >> i, 36'h0, 36'h0);
			chk(3'b101);
			rd(8'h18, 32'h105);
			wr(8'h00, {27'h0, 1'b1, codes[i]});
			chk(3'b100);
		end
		for (int k = 0; k < 6; k++) begin
			drv(10'h000, 36'h8, {32'h0, k < 3, 3'h0});
			wr(8'h00, 32'h4 + k % 3);
			chk({2'b00, (k < 3) ? k != 1 : k != 3});
		end
		$display("source test done");
		wr(8'h00, 32'h0);
		wr(8'h08, 32'h10);
		for (int j = 0; j < 3; j++) begin
			drv(10'h000, 36'h0, 36'h0);
			wr(8'(4 * j), 32'h7);
			rd(8'(12 + 4 * j), 32'h1);
			wr(8'(12 + 4 * j), 32'h24);
			wr(8'(12 + 4 * j), 32'h25);
			wr(8'(12 + 4 * j), 32'h0);
			rd(8'(12 + 4 * j), 32'h24);
			drv(10'h000, 36'h4_0000_0000, 36'h0);
			chk(3'b000);
			drv(10'h000, 36'h8_0000_0000, 36'h0);
			chk(3'b001 << j);
			wr(8'(4 * j), 32'h1);
			rd(8'(12 + 4 * j), 32'h0);
			wr(8'(12 + 4 * j), 32'h5);
			wr(8'(4 * j), 32'h7);
			rd(8'(12 + 4 * j), 32'h24);
			wr(8'(4 * j), 32'h0);
		end
		$display("alarm test done");
		wr(8'h00, 32'h1F);
		wr(8'h1C, 32'h3);
		rd(8'h00, 32'h10);
		rd(8'h1C, 32'h0);
		$display("refusal test done");
		results();
	end
	initial begin
		#200000;
		err_count++;
		results();
	end
endmodule // test_cos_top
`default_nettype wire
